// *** fbpc_check.sv ***
/*
 * Flash block protect check: control register, protect byte latch and
 * the overlap check that drops program or erase select.
 * Assumes the flash array presents the protect byte on i_prot_data and
 * the CPU bus gives single-cycle read/write strobes with an address.
 */
`timescale 1ns/1ps
module fbpc_check
    import fbpc_pkg::*;
(
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // CPU bus
    input wire logic [15:0] i_addr,
    input wire logic i_ctrl_wr,
    input wire logic [7:0] i_ctrl_wdata,
    input wire logic i_rd,
    input wire logic i_arr_wr,
    // Protect byte from the array cell
    input wire logic [7:0] i_prot_data,
    // Test level voltage on the interrupt pin
    input wire logic i_test_level_voltage,
    // Status
    output logic [7:0] o_flash_control_reg,
    output logic [7:0] o_prot_latched,
    output logic [15:0] o_target_addr,
    output logic o_prot_write_ok,
    output logic o_blocked
);
    logic [7:0] ctrl_reg;
    logic [7:0] prot_reg;
    logic [15:0] tgt_reg;
    logic blocked_reg;
    logic tgt_armed_reg;
    logic [15:0] guard_lo;
    logic [15:0] blk_mask;
    logic [15:0] blk_lo;
    logic [15:0] blk_hi;
    logic overlap;
    logic sel_any;
    logic [7:0] wr_val;
    logic [7:0] ctrl_next;

    // Lowest start among set guard bits
    always_comb begin
        guard_lo = FBPC_NONE_LO;
        if (prot_reg[3]) guard_lo = FBPC_G3_LO;
        if (prot_reg[2]) guard_lo = FBPC_G2_LO;
        if (prot_reg[1]) guard_lo = FBPC_G1_LO;
        if (prot_reg[0]) guard_lo = FBPC_G0_LO;
    end

    always_comb begin
        case ({ctrl_reg[FBPC_BLK1_BIT], ctrl_reg[FBPC_BLK0_BIT]})
            2'b00: blk_mask = FBPC_MASK_FULL;
            2'b01: blk_mask = FBPC_MASK_HALF;
            2'b10: blk_mask = FBPC_MASK_64;
            default: blk_mask = FBPC_MASK_ROW;
        endcase
    end

    // Target range: block for erase, one byte for program
    always_comb begin
        if (ctrl_reg[FBPC_ERASE_BIT]) begin
            blk_lo = tgt_reg & blk_mask;
            blk_hi = tgt_reg | ~blk_mask;
        end else begin
            blk_lo = tgt_reg;
            blk_hi = tgt_reg;
        end
    end

    // Overlap with guarded user range or vector region
    always_comb begin
        overlap = 1'b0;
        if (prot_reg != 8'h00 && !i_test_level_voltage) begin
            if (blk_lo <= FBPC_USR_HI && blk_hi >= guard_lo) overlap = 1'b1;
            if (blk_hi >= FBPC_VEC_LO) overlap = 1'b1;
        end
        // Protect byte cell itself needs the test level
        if (!i_test_level_voltage && blk_lo <= FBPC_PROT_ADDR && blk_hi >= FBPC_PROT_ADDR) overlap = 1'b1;
    end

    assign sel_any = ctrl_reg[FBPC_PGM_BIT] | ctrl_reg[FBPC_ERASE_BIT];

    // Control register write with interlocks
    always_comb begin
        wr_val = i_ctrl_wdata & FBPC_CTRL_WMASK;
        if (wr_val[FBPC_PGM_BIT] && wr_val[FBPC_ERASE_BIT]) begin
            wr_val[FBPC_ERASE_BIT] = ctrl_reg[FBPC_ERASE_BIT];
            wr_val[FBPC_PGM_BIT] = ctrl_reg[FBPC_PGM_BIT];
        end
        if (!(wr_val[FBPC_PGM_BIT] | wr_val[FBPC_ERASE_BIT]) || blocked_reg) begin
            wr_val[FBPC_HIGH_VOLTAGE_ENABLE_BIT] = 1'b0;
        end
        // Closes the gap before blocked_reg rises
        if (!tgt_armed_reg || overlap) begin
            wr_val[FBPC_HIGH_VOLTAGE_ENABLE_BIT] = 1'b0;
        end
        if (wr_val[FBPC_HIGH_VOLTAGE_ENABLE_BIT]) wr_val[FBPC_MARGIN_BIT] = 1'b0;
        ctrl_next = i_ctrl_wr ? wr_val : ctrl_reg;
        if (blocked_reg && !ctrl_reg[FBPC_HIGH_VOLTAGE_ENABLE_BIT] && !i_ctrl_wr) begin
            ctrl_next[FBPC_PGM_BIT] = 1'b0;
            ctrl_next[FBPC_ERASE_BIT] = 1'b0;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) ctrl_reg <= FBPC_CTRL_RESET;
        else ctrl_reg <= ctrl_next;
    end

    // Latch protect byte on read of its array location
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) prot_reg <= FBPC_PROT_RESET;
        else if (i_rd && i_addr == FBPC_PROT_ADDR) prot_reg <= i_prot_data;
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) tgt_reg <= FBPC_ARR_LO;
        else if (i_arr_wr && sel_any && !ctrl_reg[FBPC_HIGH_VOLTAGE_ENABLE_BIT]) tgt_reg <= i_addr;
    end

    // Check only a target latched while some select stayed set; disarmed only once neither select is set
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) tgt_armed_reg <= 1'b0;
        else if (i_arr_wr && sel_any && !ctrl_reg[FBPC_HIGH_VOLTAGE_ENABLE_BIT]) tgt_armed_reg <= 1'b1;
        else if (!sel_any) tgt_armed_reg <= 1'b0;
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) blocked_reg <= 1'b0;
        else blocked_reg <= sel_any && tgt_armed_reg && overlap;
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            o_flash_control_reg <= FBPC_CTRL_RESET;
            o_prot_latched <= FBPC_PROT_RESET;
            o_target_addr <= FBPC_ARR_LO;
            o_prot_write_ok <= 1'b0;
            o_blocked <= 1'b0;
        end else begin
            o_flash_control_reg <= ctrl_next;
            o_prot_latched <= prot_reg;
            o_target_addr <= tgt_reg;
            o_prot_write_ok <= i_test_level_voltage;
            o_blocked <= blocked_reg;
        end
    end

    // Control interlocks
    a_sel_exclusive: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        !(ctrl_reg[FBPC_PGM_BIT] && ctrl_reg[FBPC_ERASE_BIT]))
        else $error("Both selects set");
    a_high_voltage_enable_needs_sel: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        ctrl_reg[FBPC_HIGH_VOLTAGE_ENABLE_BIT] |-> sel_any)
        else $error("High voltage without select");
    a_high_voltage_enable_refused: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (i_ctrl_wr && (blocked_reg || overlap || !tgt_armed_reg)) |=> !ctrl_reg[FBPC_HIGH_VOLTAGE_ENABLE_BIT])
        else $error("High voltage taken on guarded target");
    a_high_voltage_enable_rise_safe: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        $rose(ctrl_reg[FBPC_HIGH_VOLTAGE_ENABLE_BIT]) |-> ($past(tgt_armed_reg) && !$past(overlap)))
        else $error("High voltage rose without clear check");
    a_blocked_clears: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (blocked_reg && !ctrl_reg[FBPC_HIGH_VOLTAGE_ENABLE_BIT] && !i_ctrl_wr) |=> !sel_any)
        else $error("Select not cleared");
    a_prot_latch: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (i_rd && i_addr == FBPC_PROT_ADDR) |=> prot_reg == $past(i_prot_data))
        else $error("Protect byte not latched");
    a_tgt_latch: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (i_arr_wr && sel_any && !ctrl_reg[FBPC_HIGH_VOLTAGE_ENABLE_BIT]) |=> tgt_reg == $past(i_addr))
        else $error("Target address not latched");
    a_armed_block: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (sel_any && tgt_armed_reg && overlap) |=> blocked_reg)
        else $error("Overlap not blocked");
    a_stale_target: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        !tgt_armed_reg |=> !blocked_reg)
        else $error("Blocked on unlatched target");

    // Range and bypass
    a_zero_open: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (prot_reg == 8'h00 && blk_hi < FBPC_PROT_ADDR) |-> !overlap)
        else $error("Open array flagged");
    a_guard3_range: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (prot_reg[3] && !i_test_level_voltage && blk_lo <= FBPC_USR_HI && blk_hi >= FBPC_G3_LO) |-> overlap)
        else $error("Top guard range open");
    a_vector_guard: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (prot_reg != 8'h00 && !i_test_level_voltage && blk_hi >= FBPC_VEC_LO) |-> overlap)
        else $error("Vector region open");
    a_union_low: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (prot_reg[0] && !i_test_level_voltage && blk_lo == FBPC_G0_LO) |-> overlap)
        else $error("Lowest guard missed");
    a_prot_cell_guard: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (!i_test_level_voltage && blk_lo <= FBPC_PROT_ADDR && blk_hi >= FBPC_PROT_ADDR) |-> overlap)
        else $error("Protect cell open without test level");
    a_write_ok_copy: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        1'b1 |=> o_prot_write_ok == $past(i_test_level_voltage))
        else $error("Protect write status wrong");
    a_test_bypass: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        i_test_level_voltage |-> !overlap)
        else $error("Bypass ignored");

    c_blocked: cover property (@(posedge i_mclk) blocked_reg);
    c_high_voltage_enable_set: cover property (@(posedge i_mclk) ctrl_reg[FBPC_HIGH_VOLTAGE_ENABLE_BIT]);
    c_bypass_erase: cover property (@(posedge i_mclk) i_test_level_voltage && ctrl_reg[FBPC_ERASE_BIT]);
    c_high_voltage_enable_unarmed: cover property (@(posedge i_mclk) i_ctrl_wr && i_ctrl_wdata[FBPC_HIGH_VOLTAGE_ENABLE_BIT] && !tgt_armed_reg);
    c_guarded_program: cover property (@(posedge i_mclk) ctrl_reg[FBPC_PGM_BIT] && tgt_armed_reg && overlap);
endmodule

// *** fbpc_check_tb.sv ***
/*
 * Self-checking bench for the flash block protect check.
 * Assumes fbpc_pkg and fbpc_check compile first; bench drives all ports.
 */
`timescale 1ns/1ps
module fbpc_check_tb;
import fbpc_pkg::*;
typedef struct packed {logic b; logic [7:0] c; logic [7:0] p; logic v; logic [15:0] t;} fbpc_exp_t;
logic i_mclk = 0, i_rst_n = 0, i_ctrl_wr = 0, i_rd = 0, i_arr_wr = 0, i_test_level_voltage = 0, chk = 0;
logic [15:0] i_addr = '0;
logic [7:0] i_ctrl_wdata = '0, i_prot_data = '0;
logic [7:0] o_flash_control_reg, o_prot_latched;
logic [15:0] o_target_addr;
logic o_prot_write_ok, o_blocked;
fbpc_exp_t q[$];
int errors = 0, comparisons = 0, cyc = 0;
logic [15:0] los[4] = '{FBPC_G0_LO, FBPC_G1_LO, FBPC_G2_LO, FBPC_G3_LO};
fbpc_check i_dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_ctrl_wr(i_ctrl_wr),
    .i_ctrl_wdata(i_ctrl_wdata), .i_rd(i_rd), .i_arr_wr(i_arr_wr), .i_prot_data(i_prot_data),
    .i_test_level_voltage(i_test_level_voltage), .o_flash_control_reg(o_flash_control_reg),
    .o_prot_latched(o_prot_latched), .o_target_addr(o_target_addr), .o_prot_write_ok(o_prot_write_ok),
    .o_blocked(o_blocked));
initial forever #2 i_mclk = ~i_mclk;
task final_report;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
endtask
task cmp(string n, logic [7:0] e, logic [7:0] s);
    comparisons++;
    if (s !== e) begin
        errors++;
        $display("BAD %s exp %h got %h", n, e, s);
    end
endtask
task cmp_addr(string n, logic [15:0] e, logic [15:0] s);
    comparisons++;
    if (s !== e) begin
        errors++;
        $display("BAD %s exp %h got %h", n, e, s);
    end
endtask
always @(posedge i_mclk) begin
    cyc++;
    if (chk) begin
        cmp("blocked", {7'h0, q[0].b}, {7'h0, o_blocked});
        cmp("control", q[0].c, o_flash_control_reg);
        cmp("latched", q[0].p, o_prot_latched);
        cmp("write_ok", {7'h0, q[0].v}, {7'h0, o_prot_write_ok});
        cmp_addr("target", q[0].t, o_target_addr);
        q.pop_front();
    end
    if (cyc == 20000) begin
        errors++;
        final_report;
    end
end
task wr(logic [7:0] d);
    @(negedge i_mclk);
    i_ctrl_wr = 1;
    i_ctrl_wdata = d;
    @(negedge i_mclk);
    i_ctrl_wr = 0;
endtask
task expect_now(logic b, logic [7:0] c, logic [7:0] p, logic v, logic [15:0] t);
    q.push_back('{b, c, p, v, t});
    chk = 1;
    @(negedge i_mclk);
    chk = 0;
endtask
task rst(logic tv);
    @(negedge i_mclk);
    i_rst_n = 0;
    i_test_level_voltage = tv;
    @(negedge i_mclk);
    i_rst_n = 1;
endtask
task op(logic pg, logic [1:0] bk, logic [15:0] a, logic [7:0] p, logic tv);
    logic [15:0] m, t, h, lo;
    logic b;
    logic [7:0] c;
    m = bk == 0 ? FBPC_MASK_FULL : bk == 1 ? FBPC_MASK_HALF : bk == 2 ? FBPC_MASK_64 : FBPC_MASK_ROW;
    t = pg ? a : a & m;
    h = pg ? a : a | ~m;
    lo = p[0] ? los[0] : p[1] ? los[1] : p[2] ? los[2] : p[3] ? los[3] : FBPC_NONE_LO;
    b = tv ? 1'b0 : (t <= FBPC_PROT_ADDR && h >= FBPC_PROT_ADDR) ? 1'b1 :
        p[3:0] == 0 ? 1'b0 : (h >= lo && t <= FBPC_USR_HI) || h >= FBPC_VEC_LO;
    c = {2'b00, bk, 2'b00, !pg, pg};
    rst(tv);
    wr(c);
    i_rd = 1;
    i_addr = FBPC_PROT_ADDR;
    i_prot_data = p;
    @(negedge i_mclk);
    i_rd = 0;
    i_arr_wr = 1;
    i_addr = a;
    @(negedge i_mclk);
    i_arr_wr = 0;
    repeat (2) @(negedge i_mclk);
    expect_now(b, b ? c & 8'hfc : c, p, tv, a);
    wr(c | 8'h0c);
    repeat (2) @(negedge i_mclk);
    expect_now(1'b0, b ? c | 8'h04 : c | 8'h08, p, tv, a);
endtask
initial begin
    logic [7:0] d;
    d = $urandom(24);
    repeat (5) @(negedge i_mclk);
    i_rst_n = 1;
    expect_now(1'b0, 8'h00, 8'h00, 1'b0, FBPC_ARR_LO);
    foreach (los[i]) begin
        op(1'b1, 2'b00, los[i] - 16'h1, 8'h01 << i, 1'b0);
        op(1'b1, 2'b00, los[i], 8'h01 << i, 1'b0);
    end
    op(1'b1, 2'b00, 16'h7ff0, 8'h0f, 1'b0);
    op(1'b1, 2'b00, 16'h7880, 8'h06, 1'b0);
    op(1'b1, 2'b00, FBPC_PROT_ADDR, 8'h00, 1'b0);
    op(1'b1, 2'b00, FBPC_PROT_ADDR, 8'h0f, 1'b1);
    rst(1'b0);
    wr(8'h01);
    wr(8'h03);
    expect_now(1'b0, 8'h01, 8'h00, 1'b0, FBPC_ARR_LO);
    wr(8'h08);
    expect_now(1'b0, 8'h00, 8'h00, 1'b0, FBPC_ARR_LO);
    repeat (80) begin
        d = $urandom % 2;
        op(d[0], 2'($urandom), d[0] && $urandom % 4 == 0 ? 16'hfff0 | 16'($urandom % 16) :
            16'h7800 | 16'($urandom % 2048), 8'($urandom % 16), $urandom % 6 == 0);
    end
    final_report;
end
endmodule

// *** fbpc_pkg.sv ***
/*
 * Constants for the flash block protect check: control bit positions,
 * guarded address bounds, block masks and the protect byte location.
 * Assumes a 16-bit bus address space with the array at 7800-7fff.
 */
package fbpc_pkg;
    localparam int unsigned FBPC_ADDR_W = 16;
    localparam int unsigned FBPC_CTRL_W = 8;
    // Control register bit positions
    localparam int unsigned FBPC_PGM_BIT = 0;
    localparam int unsigned FBPC_ERASE_BIT = 1;
    localparam int unsigned FBPC_MARGIN_BIT = 2;
    localparam int unsigned FBPC_HIGH_VOLTAGE_ENABLE_BIT = 3;
    localparam int unsigned FBPC_BLK0_BIT = 4;
    localparam int unsigned FBPC_BLK1_BIT = 5;
    localparam int unsigned FBPC_FDIV_BIT = 7;
    localparam logic [7:0] FBPC_CTRL_RESET = 8'h00;
    localparam logic [7:0] FBPC_CTRL_WMASK = 8'hbf;
    localparam logic [7:0] FBPC_PROT_RESET = 8'h00;
    // Addresses
    localparam logic [15:0] FBPC_PROT_ADDR = 16'hfff0;
    localparam logic [15:0] FBPC_VEC_LO = 16'hfff0;
    localparam logic [15:0] FBPC_VEC_HI = 16'hffff;
    localparam logic [15:0] FBPC_ARR_LO = 16'h7800;
    localparam logic [15:0] FBPC_USR_HI = 16'h7fef;
    localparam logic [15:0] FBPC_G3_LO = 16'h7a00;
    localparam logic [15:0] FBPC_G2_LO = 16'h7900;
    localparam logic [15:0] FBPC_G1_LO = 16'h7880;
    localparam logic [15:0] FBPC_G0_LO = 16'h7800;
    localparam logic [15:0] FBPC_NONE_LO = 16'hffff;
    // Erase block masks by {blk1,blk0}
    localparam logic [15:0] FBPC_MASK_FULL = 16'hf800;
    localparam logic [15:0] FBPC_MASK_HALF = 16'hfc00;
    localparam logic [15:0] FBPC_MASK_64 = 16'hffc0;
    localparam logic [15:0] FBPC_MASK_ROW = 16'hfff8;
endpackage
